//--- shared/scpf_pkg.sv
// scpf_pkg: constants, states and request type of the serial control port framing block
// assumes: a host shifts one byte per select-low period on serial_shift_clock
package scpf_pkg;

  localparam int BYTE_W = 8;
  localparam int CNT_W  = 16;
  localparam int LEN_W  = 3;

  // edge counts that classify a select-low period
  localparam logic [CNT_W-1:0] EDGES_BYTE  = 16'h0008;
  localparam logic [CNT_W-1:0] EDGES_RESET = 16'h0010;

  // opcodes the port decodes; only hardware reset and channel enable are handled inside
  localparam logic [BYTE_W-1:0] OP_SOFT_RST = 8'h02;
  localparam logic [BYTE_W-1:0] OP_HW_RST   = 8'h04;
  localparam logic [BYTE_W-1:0] OP_NOP      = 8'h06;
  localparam logic [BYTE_W-1:0] OP_CHEN_WR  = 8'h4A;
  localparam logic [BYTE_W-1:0] OP_CHEN_RD  = 8'h4B;
  localparam logic [BYTE_W-1:0] OP_REV_RD   = 8'h73;

  // channel enable and operating mode byte
  localparam int                CHEN_FIRST = 0;
  localparam int                CHEN_SECOND = 1;
  localparam logic [BYTE_W-1:0] CHEN_RST   = 8'h00;
  localparam logic [BYTE_W-1:0] BYTE_RST   = 8'h00;

  // channel codes on a request
  localparam logic [1:0] CHAN_NONE   = 2'h0;
  localparam logic [1:0] CHAN_FIRST  = 2'h1;
  localparam logic [1:0] CHAN_SECOND = 2'h2;

  // data byte counts
  localparam logic [LEN_W-1:0] LEN_NONE = 3'h0;
  localparam logic [LEN_W-1:0] LEN_ONE  = 3'h1;
  localparam logic [LEN_W-1:0] LEN_TWO  = 3'h2;

  // synchroniser idle value, select and clock resting high
  localparam logic [2:0] SYNC_RST = 3'h7;

  typedef enum logic [3:0] {
    ST_CMD    = 4'h1,
    ST_WDATA  = 4'h2,
    ST_RFETCH = 4'h4,
    ST_RDATA  = 4'h8
  } scpf_state_t;

  typedef struct packed {
    logic              valid;
    logic              read;
    logic              glob;
    logic [BYTE_W-1:0] opcode;
    logic [LEN_W-1:0]  index;
    logic [BYTE_W-1:0] data;
    logic [1:0]        chan;
  } scpf_req_t;

  localparam scpf_req_t REQ_IDLE = '0;

  function automatic logic is_global(input logic [BYTE_W-1:0] op);
    case (op)
      8'h04, 8'h06, 8'h44, 8'h45, 8'h46, 8'h47, 8'h4A, 8'h4B, 8'h4D, 8'h4F,
      8'h5E, 8'h5F, 8'h6C, 8'h6D, 8'h73, 8'hE4, 8'hE5, 8'hE6, 8'hE7: is_global = 1'b1;
      default: is_global = 1'b0;
    endcase
  endfunction

  function automatic logic [LEN_W-1:0] data_len(input logic [BYTE_W-1:0] op);
    case (op)
      OP_SOFT_RST, OP_HW_RST, OP_NOP: data_len = LEN_NONE;
      OP_REV_RD:                      data_len = LEN_TWO;
      default:                        data_len = LEN_ONE;
    endcase
  endfunction

endpackage

//--- src/scpf_core.sv
// scpf_core: byte framing, command sequencing and output shifting of the serial control port
// assumes: clk at 250 MHz; serial_shift_clock and cs_n come from the host; register contents except the channel enable byte live outside
`timescale 1ns/1ps

module scpf_core (
  // system
  input  wire logic                          clk,
  input  wire logic                          rst,
  // serial control port
  input  wire logic                          serial_shift_clock,
  input  wire logic                          cs_n,
  input  wire logic                          sdi,
  output logic                               sdo,
  // device side
  output scpf_pkg::scpf_req_t                req,
  input  wire logic                          rd_valid,
  input  wire logic [scpf_pkg::BYTE_W-1:0]   rd_data,
  output logic                               hw_reset,
  output logic [scpf_pkg::BYTE_W-1:0]        chan_mode
);

  // link domain
  logic [scpf_pkg::BYTE_W-1:0] lk_shift_q;
  logic [scpf_pkg::BYTE_W-1:0] lk_shift_d;
  logic [scpf_pkg::CNT_W-1:0]  lk_cnt_q;
  logic [scpf_pkg::CNT_W-1:0]  lk_cnt_d;
  logic                        link_rst_q;

  // clk domain
  logic [2:0]                  cs_sync_q;
  logic [2:0]                  cs_sync_d;
  logic [2:0]                  ck_sync_q;
  logic [2:0]                  ck_sync_d;
  logic                        hw_rst_q;
  logic                        hw_rst_d;
  logic                        rst_i;
  scpf_pkg::scpf_state_t       st_q;
  scpf_pkg::scpf_state_t       st_d;
  logic [scpf_pkg::BYTE_W-1:0] op_q;
  logic [scpf_pkg::BYTE_W-1:0] op_d;
  logic [scpf_pkg::LEN_W-1:0]  left_q;
  logic [scpf_pkg::LEN_W-1:0]  left_d;
  logic [scpf_pkg::LEN_W-1:0]  idx_q;
  logic [scpf_pkg::LEN_W-1:0]  idx_d;
  logic [scpf_pkg::BYTE_W-1:0] chen_q;
  logic [scpf_pkg::BYTE_W-1:0] chen_d;
  logic [scpf_pkg::BYTE_W-1:0] tx_q;
  logic [scpf_pkg::BYTE_W-1:0] tx_d;
  logic [scpf_pkg::BYTE_W-1:0] tx_sh_q;
  logic [scpf_pkg::BYTE_W-1:0] tx_sh_d;
  logic                        seen_q;
  logic                        seen_d;
  logic [scpf_pkg::CNT_W-1:0]  base_q;
  logic [scpf_pkg::CNT_W-1:0]  base_d;
  scpf_pkg::scpf_req_t         req_q;
  scpf_pkg::scpf_req_t         req_d;

  logic                        cs_hi;
  logic                        frame_end;
  logic                        ck_rise;
  logic                        ck_fall;
  logic [scpf_pkg::CNT_W-1:0]  frame_n;
  logic                        byte_ok;
  logic                        frame_long;
  logic [scpf_pkg::BYTE_W-1:0] rx_byte;

  // builds a request toward the register side
  function automatic scpf_pkg::scpf_req_t req_make(
    input logic                          rd,
    input logic [scpf_pkg::BYTE_W-1:0]   op,
    input logic [scpf_pkg::LEN_W-1:0]    ix,
    input logic [scpf_pkg::BYTE_W-1:0]   dat,
    input logic [scpf_pkg::BYTE_W-1:0]   picks
  );
    scpf_pkg::scpf_req_t r;
    r        = scpf_pkg::REQ_IDLE;
    r.valid  = 1'b1;
    r.read   = rd;
    r.glob   = scpf_pkg::is_global(op);
    r.opcode = op;
    r.index  = ix;
    r.data   = dat;
    if (r.glob) begin
      r.chan = scpf_pkg::CHAN_NONE;
    end else if (!rd) begin
      r.chan = picks[1:0];
    end else if (picks[scpf_pkg::CHEN_FIRST]) begin
      r.chan = scpf_pkg::CHAN_FIRST;
    end else if (picks[scpf_pkg::CHEN_SECOND]) begin
      r.chan = scpf_pkg::CHAN_SECOND;
    end else begin
      r.chan = scpf_pkg::CHAN_NONE;
    end
    return r;
  endfunction

  // link side: shift and count rising edges only while selected
  always_comb begin
    lk_shift_d = lk_shift_q;
    lk_cnt_d   = lk_cnt_q;
    if (!cs_n) begin
      lk_shift_d = {lk_shift_q[scpf_pkg::BYTE_W-2:0], sdi};
      lk_cnt_d   = lk_cnt_q + scpf_pkg::CNT_W'(1);
    end
  end

  always_ff @(posedge serial_shift_clock or posedge link_rst_q) begin
    if (link_rst_q) begin
      lk_shift_q <= scpf_pkg::BYTE_RST;
      lk_cnt_q   <= '0;
    end else begin
      lk_shift_q <= lk_shift_d;
      lk_cnt_q   <= lk_cnt_d;
    end
  end

  // select and clock synchronisers
  assign cs_sync_d = {cs_sync_q[1:0], cs_n};
  assign ck_sync_d = {ck_sync_q[1:0], serial_shift_clock};
  assign cs_hi     = cs_sync_q[1];
  assign frame_end = cs_sync_q[1] & ~cs_sync_q[2];
  assign ck_rise   = ck_sync_q[1] & ~ck_sync_q[2];
  assign ck_fall   = ~ck_sync_q[1] & ck_sync_q[2];

  // frame classification; link words are stable once select is high
  assign rx_byte    = lk_shift_q;
  assign frame_n    = lk_cnt_q - base_q;
  assign byte_ok    = frame_end && (frame_n >= scpf_pkg::EDGES_BYTE) && (frame_n < scpf_pkg::EDGES_RESET);
  assign frame_long = frame_end && (frame_n >= scpf_pkg::EDGES_RESET);
  assign rst_i      = rst | hw_rst_q;

  // command sequencer
  always_comb begin
    st_d   = st_q;
    op_d   = op_q;
    left_d = left_q;
    idx_d  = idx_q;
    chen_d = chen_q;
    tx_d   = tx_q;
    req_d  = scpf_pkg::REQ_IDLE;
    base_d = frame_end ? lk_cnt_q : base_q;
    case (st_q)
      scpf_pkg::ST_CMD: begin
        if (byte_ok) begin
          op_d   = rx_byte;
          idx_d  = '0;
          left_d = scpf_pkg::data_len(rx_byte);
          if (rx_byte == scpf_pkg::OP_HW_RST) begin
            st_d = scpf_pkg::ST_CMD;
          end else if (rx_byte[0]) begin
            if (rx_byte == scpf_pkg::OP_CHEN_RD) begin
              tx_d = chen_q;
              st_d = scpf_pkg::ST_RDATA;
            end else begin
              req_d = req_make(1'b1, rx_byte, '0, scpf_pkg::BYTE_RST, chen_q);
              st_d  = scpf_pkg::ST_RFETCH;
            end
          end else if (scpf_pkg::data_len(rx_byte) == scpf_pkg::LEN_NONE) begin
            req_d = req_make(1'b0, rx_byte, '0, scpf_pkg::BYTE_RST, chen_q);
          end else begin
            st_d = scpf_pkg::ST_WDATA;
          end
        end
      end
      scpf_pkg::ST_WDATA: begin
        if (byte_ok) begin
          if (op_q == scpf_pkg::OP_CHEN_WR) begin
            chen_d = rx_byte;
          end else begin
            req_d = req_make(1'b0, op_q, idx_q, rx_byte, chen_q);
          end
          idx_d  = idx_q + scpf_pkg::LEN_W'(1);
          left_d = left_q - scpf_pkg::LEN_W'(1);
          if (left_q == scpf_pkg::LEN_ONE) begin
            st_d = scpf_pkg::ST_CMD;
          end
        end
      end
      scpf_pkg::ST_RFETCH: begin
        if (rd_valid) begin
          tx_d = rd_data;
          st_d = scpf_pkg::ST_RDATA;
        end
      end
      scpf_pkg::ST_RDATA: begin
        if (frame_end) begin
          idx_d  = idx_q + scpf_pkg::LEN_W'(1);
          left_d = left_q - scpf_pkg::LEN_W'(1);
          if (left_q == scpf_pkg::LEN_ONE) begin
            st_d = scpf_pkg::ST_CMD;
          end else begin
            req_d = req_make(1'b1, op_q, idx_d, scpf_pkg::BYTE_RST, chen_q);
            st_d  = scpf_pkg::ST_RFETCH;
          end
        end
      end
      default: begin
        st_d = scpf_pkg::ST_CMD;
      end
    endcase
  end

  // over-long frames always reset, whatever the sequencer state
  always_comb begin
    hw_rst_d = frame_long;
    if (st_q == scpf_pkg::ST_CMD && byte_ok && rx_byte == scpf_pkg::OP_HW_RST) begin
      hw_rst_d = 1'b1;
    end
  end

  // output shifter: bit 7 waits on sdo before select falls
  always_comb begin
    seen_d  = cs_hi ? 1'b0 : (seen_q | ck_rise);
    tx_sh_d = tx_sh_q;
    if (st_q != scpf_pkg::ST_RDATA || cs_hi) begin
      tx_sh_d = tx_d;
    end else if (ck_fall && seen_q) begin
      tx_sh_d = {tx_sh_q[scpf_pkg::BYTE_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cs_sync_q  <= scpf_pkg::SYNC_RST;
      ck_sync_q  <= scpf_pkg::SYNC_RST;
      hw_rst_q   <= 1'b0;
      link_rst_q <= 1'b1;
    end else begin
      cs_sync_q  <= cs_sync_d;
      ck_sync_q  <= ck_sync_d;
      hw_rst_q   <= hw_rst_d;
      link_rst_q <= hw_rst_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst_i) begin
      st_q    <= scpf_pkg::ST_CMD;
      op_q    <= scpf_pkg::BYTE_RST;
      left_q  <= scpf_pkg::LEN_NONE;
      idx_q   <= scpf_pkg::LEN_NONE;
      chen_q  <= scpf_pkg::CHEN_RST;
      tx_q    <= scpf_pkg::BYTE_RST;
      tx_sh_q <= scpf_pkg::BYTE_RST;
      seen_q  <= 1'b0;
      base_q  <= '0;
      req_q   <= scpf_pkg::REQ_IDLE;
    end else begin
      st_q    <= st_d;
      op_q    <= op_d;
      left_q  <= left_d;
      idx_q   <= idx_d;
      chen_q  <= chen_d;
      tx_q    <= tx_d;
      tx_sh_q <= tx_sh_d;
      seen_q  <= seen_d;
      base_q  <= base_d;
      req_q   <= req_d;
    end
  end

  // bits past the eighth shift out as zeros; outside a read-out sdo shows bit 7 of the fetched byte
  assign sdo       = tx_sh_q[scpf_pkg::BYTE_W-1];
  assign req       = req_q;
  assign hw_reset  = hw_rst_q;
  assign chan_mode = chen_q;

  // checks
  property p_short_frame;
    @(posedge clk) disable iff (rst)
    (frame_end && frame_n < scpf_pkg::EDGES_BYTE && !hw_rst_q && (st_q == scpf_pkg::ST_CMD || st_q == scpf_pkg::ST_WDATA))
      |=> ($stable(st_q) && $stable(chen_q) && !req_q.valid);
  endproperty
  a_short_frame: assert property (p_short_frame) else $error("short frame was not discarded");

  property p_long_frame;
    @(posedge clk) disable iff (rst)
    frame_long |=> hw_rst_q ##1 (st_q == scpf_pkg::ST_CMD && chen_q == scpf_pkg::CHEN_RST);
  endproperty
  a_long_frame: assert property (p_long_frame) else $error("long frame did not reset");

  property p_hw_cmd;
    @(posedge clk) disable iff (rst)
    (st_q == scpf_pkg::ST_CMD && byte_ok && rx_byte == scpf_pkg::OP_HW_RST) |=> hw_rst_q ##1 (link_rst_q && !req_q.valid);
  endproperty
  a_hw_cmd: assert property (p_hw_cmd) else $error("reset command did not reset");

  property p_reset_defaults;
    @(posedge clk) disable iff (rst)
    hw_rst_q |=> (st_q == scpf_pkg::ST_CMD && left_q == scpf_pkg::LEN_NONE && base_q == '0);
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("defaults not restored");

  property p_write_mask;
    @(posedge clk) disable iff (rst)
    (req_q.valid && !req_q.read && !req_q.glob) |-> req_q.chan == chen_q[1:0];
  endproperty
  a_write_mask: assert property (p_write_mask) else $error("write not sent to all enabled channels");

  property p_read_lowest;
    @(posedge clk) disable iff (rst)
    (req_q.valid && req_q.read && !req_q.glob && chen_q[scpf_pkg::CHEN_FIRST]) |-> req_q.chan == scpf_pkg::CHAN_FIRST;
  endproperty
  a_read_lowest: assert property (p_read_lowest) else $error("read not from first enabled channel");

  property p_global;
    @(posedge clk) disable iff (rst)
    (req_q.valid && scpf_pkg::is_global(req_q.opcode)) |-> (req_q.glob && req_q.chan == scpf_pkg::CHAN_NONE);
  endproperty
  a_global: assert property (p_global) else $error("global command carried channel picks");

  property p_refuse;
    @(posedge clk) disable iff (rst)
    (st_q == scpf_pkg::ST_RDATA && frame_end && left_q != scpf_pkg::LEN_ONE && !frame_long) |=> st_q == scpf_pkg::ST_RFETCH;
  endproperty
  a_refuse: assert property (p_refuse) else $error("command taken while output pending");

  property p_first_bit;
    @(posedge clk) disable iff (rst)
    (st_q == scpf_pkg::ST_RDATA && cs_hi) |=> (sdo == $past(tx_d[scpf_pkg::BYTE_W-1]));
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("first output bit not ready");

  property p_idle_hold;
    @(posedge clk) disable iff (rst)
    (cs_sync_q[1] && cs_sync_q[2] && !hw_rst_q && st_q != scpf_pkg::ST_RFETCH) |=> ($stable(chen_q) && $stable(st_q));
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("state changed while deselected");

endmodule

//--- testbench/scpf_host.sv
// scpf_host: host model on the serial control port, n shifted bits per select-low period
// assumes: shift clock period 32 ns, resting high between frames apart from the 200 ns low rest in toggle, phase unrelated to clk
`timescale 1ns/1ps
module scpf_host (
  // serial control port
  output logic      serial_shift_clock,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo
);
  initial begin
    serial_shift_clock = 1'b1;
    cs_n               = 1'b1;
    sdi                = 1'b0;
  end

  // n rising edges, bits sent from bit n-1 down; got keeps the last 8 sampled output bits
  task automatic frame(input int n, input logic [15:0] bits, output logic [7:0] got, output logic first);
    got = 8'h00;
    #0.7 cs_n = 1'b0;
    #4 first = sdo;
    for (int i = n - 1; i >= 0; i--) begin
      #4 serial_shift_clock = 1'b0;
      sdi = bits[i];
      #20 serial_shift_clock = 1'b1;
      got = {got[6:0], sdo};
      #8;
    end
    cs_n = 1'b1;
    sdi  = ~sdi;
    #40;
  endtask

  // clock runs with select high, then rests low while deselected
  task automatic toggle(input int n);
    repeat (n) begin
      #16 serial_shift_clock = 1'b0;
      #16 serial_shift_clock = 1'b1;
    end
    serial_shift_clock = 1'b0;
    #200 serial_shift_clock = 1'b1;
    #16;
  endtask
endmodule

//--- testbench/scpf_core_test.sv
// scpf_core_test: self-checking bench of the serial control port framing block
// assumes: scpf_host drives the link; this bench answers reads on the device side
`timescale 1ns/1ps
module scpf_core_test;
  logic                        clk;
  logic                        rst;
  logic                        serial_shift_clock;
  logic                        cs_n;
  logic                        sdi;
  logic                        sdo;
  scpf_pkg::scpf_req_t         req;
  logic                        rd_valid;
  logic [scpf_pkg::BYTE_W-1:0] rd_data;
  logic                        hw_reset;
  logic [scpf_pkg::BYTE_W-1:0] chan_mode;
  int                          error_cnt;
  int                          samples_checked;
  scpf_pkg::scpf_req_t         req_q[$];
  int                          rst_q[$];
  logic [7:0]                  got;
  logic                        first;
  logic [7:0]                  val;
  logic [1:0]                  pk;
  logic [7:0]                  gops[6] = '{8'h44, 8'h46, 8'h5E, 8'h6C, 8'hE4, 8'h06};

  scpf_core dut_u (.clk(clk), .rst(rst), .serial_shift_clock(serial_shift_clock), .cs_n(cs_n), .sdi(sdi),
                   .sdo(sdo), .req(req), .rd_valid(rd_valid), .rd_data(rd_data), .hw_reset(hw_reset),
                   .chan_mode(chan_mode));
  scpf_host host_u (.serial_shift_clock(serial_shift_clock), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

  initial clk = 1'b0;
  always #2 clk = ~clk;

  task automatic fail(input string msg);
    $display("CHECK FAILED at %0t: %s", $time, msg);
    error_cnt++;
  endtask

  task automatic cmp_byte(input logic [7:0] exp, input logic [7:0] act);
    samples_checked++;
    if (act !== exp) fail($sformatf("byte %h expected %h", act, exp));
  endtask

  task automatic cmp_req(input scpf_pkg::scpf_req_t exp, input scpf_pkg::scpf_req_t act);
    samples_checked++;
    if (act.read !== exp.read || act.glob !== exp.glob || act.opcode !== exp.opcode || act.chan !== exp.chan ||
        act.index !== exp.index || (!exp.read && act.data !== exp.data)) fail($sformatf("request %h expected %h", act, exp));
  endtask

  task automatic print_verdict;
    if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // command frame, then one data frame unless the command carries none
  task automatic wr(input logic [7:0] op, input logic [7:0] dat, input logic gl, input logic [1:0] ch, input bit nod);
    if (op == scpf_pkg::OP_HW_RST) rst_q.push_back(1);
    else if (op != scpf_pkg::OP_CHEN_WR) req_q.push_back('{1'b1, 1'b0, gl, op, 3'h0, dat, ch});
    host_u.frame(8, {8'h00, op}, got, first);
    if (!nod) host_u.frame(8, {8'h00, dat}, got, first);
    tick(8);
  endtask

  // read command, device-side answers, then read-out frames carrying a reset opcode that must be ignored
  task automatic rd(input logic [7:0] op, input logic [7:0] dat, input logic [7:0] dat2, input logic gl,
                    input logic [1:0] ch, input int n);
    logic [7:0] exp_b;
    if (op != scpf_pkg::OP_CHEN_RD) req_q.push_back('{1'b1, 1'b1, gl, op, 3'h0, 8'h00, ch});
    host_u.frame(8, {8'h00, op}, got, first);
    for (int b = 0; b < n; b++) begin
      exp_b    = (b == 0) ? dat : dat2;
      tick(1);
      rd_valid = 1'b1;
      rd_data  = exp_b;
      tick(1);
      rd_valid = 1'b0;
      tick(4);
      if (b + 1 < n) req_q.push_back('{1'b1, 1'b1, gl, op, 3'h1, 8'h00, ch});
      host_u.frame(8, {8'h00, scpf_pkg::OP_HW_RST}, got, first);
      cmp_byte(exp_b, got);
      cmp_byte({7'h00, exp_b[7]}, {7'h00, first});
    end
    tick(8);
  endtask

  always @(posedge clk) begin
    if (!rst && req.valid === 1'b1) begin
      if (req_q.size() == 0) fail("unexpected request");
      else cmp_req(req_q.pop_front(), req);
    end
    if (!rst && hw_reset === 1'b1) begin
      samples_checked++;
      if (rst_q.size() == 0) fail("unexpected hardware reset");
      else rst_q.delete(0);
    end
  end

  initial begin
    #100000;
    fail("timeout");
    print_verdict();
  end

  initial begin
    rst             = 1'b1;
    rd_valid        = 1'b0;
    rd_data         = 8'h00;
    error_cnt       = 0;
    samples_checked = 0;
    void'($urandom(32'hB23A));
    tick(2);
    rst = 1'b0;
    tick(4);
    cmp_byte(scpf_pkg::CHEN_RST, chan_mode);
    for (int k = 1; k < 4; k++) begin
      pk = k[1:0];
      wr(scpf_pkg::OP_CHEN_WR, {6'h00, pk}, 1'b1, 2'h0, 1'b0);
      cmp_byte({6'h00, pk}, chan_mode);
      rd(scpf_pkg::OP_CHEN_RD, {6'h00, pk}, 8'h00, 1'b1, 2'h0, 1);
      wr(8'h50, 8'($urandom), 1'b0, pk, 1'b0);
      rd(8'h51, 8'($urandom), 8'h00, 1'b0, pk[0] ? 2'h1 : 2'h2, 1);
      wr(scpf_pkg::OP_SOFT_RST, 8'h00, 1'b0, pk, 1'b1);
    end
    foreach (gops[i]) wr(gops[i], gops[i] == 8'h06 ? 8'h00 : 8'($urandom), 1'b1, 2'h0, gops[i] == 8'h06);
    rd(8'h47, 8'($urandom), 8'h00, 1'b1, 2'h0, 1);
    rd(scpf_pkg::OP_REV_RD, 8'($urandom), 8'($urandom), 1'b1, 2'h0, 2);
    host_u.toggle(10);
    tick(4);
    cmp_byte(8'h03, chan_mode);
    val = 8'($urandom);
    req_q.push_back('{1'b1, 1'b0, 1'b0, 8'h50, 3'h0, val, 2'h3});
    host_u.frame(8, 16'h0050, got, first);
    host_u.frame(5, 16'h001F, got, first);
    host_u.frame(8, {8'h00, val}, got, first);
    tick(8);
    val = 8'($urandom);
    req_q.push_back('{1'b1, 1'b0, 1'b0, 8'h50, 3'h0, val, 2'h3});
    host_u.frame(12, 16'h0A50, got, first);
    host_u.frame(8, {8'h00, val}, got, first);
    tick(8);
    wr(scpf_pkg::OP_HW_RST, 8'h00, 1'b1, 2'h0, 1'b1);
    cmp_byte(8'h00, chan_mode);
    wr(scpf_pkg::OP_CHEN_WR, 8'h02, 1'b1, 2'h0, 1'b0);
    rst_q.push_back(1);
    host_u.frame(16, 16'($urandom), got, first);
    tick(8);
    cmp_byte(8'h00, chan_mode);
    wr(scpf_pkg::OP_CHEN_WR, 8'h01, 1'b1, 2'h0, 1'b0);
    wr(8'h50, 8'($urandom), 1'b0, 2'h1, 1'b0);
    rd(8'h51, 8'($urandom), 8'h00, 1'b0, 2'h1, 1);
    tick(10);
    if (req_q.size() != 0 || rst_q.size() != 0) fail("expected result missing");
    print_verdict();
  end
endmodule
